// File: pkg/aie_map.svh
// register offsets, opcode patterns, flag positions and reset values of the add execute block
`ifndef AIE_MAP_SVH
`define AIE_MAP_SVH

// register offsets on the plain register port
`define AIE_REG_CTRL 4'h0
`define AIE_REG_ACC 4'h1
`define AIE_REG_FLAGS 4'h2
`define AIE_REG_BANK 4'h3
`define AIE_REG_IDX 4'h4
`define AIE_REG_STAT 4'h5

// control register fields
`define AIE_CTRL_EXT 0

// status register fields
`define AIE_STAT_BUSY 0

// opcode patterns
`define AIE_OPC_LIT 8'h0f
`define AIE_OPC_FILE 6'h09
`define AIE_BIT_DEST 9
`define AIE_BIT_BANK 8

// flag bit positions
`define AIE_F_C 0
`define AIE_F_DC 1
`define AIE_F_Z 2
`define AIE_F_OV 3
`define AIE_F_N 4

// addressing constants
`define AIE_IDX_LIMIT 8'h5f
`define AIE_ACCESS_SPLIT 8'h80
`define AIE_SFR_PAGE 4'hf
`define AIE_LOW_PAGE 4'h0

// reset values
`define AIE_ACC_RST 8'h00
`define AIE_FLAGS_RST 5'h00
`define AIE_BANK_RST 4'h0
`define AIE_IDX_RST 12'h000
`define AIE_EXT_RST 1'b0

`endif

// File: pkg/aie_pkg.sv
// types shared by the add execute block
package aie_pkg;

  // instruction phases, one per clock
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DECODE,
    ST_READ,
    ST_PROC,
    ST_WRITE
  } aie_state_e;

  // recognised instruction kinds
  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_LIT,
    KIND_FILE
  } aie_kind_e;

endpackage

// File: logic/aie_adder.sv
// 8-bit adder with carry, digit carry, zero, overflow and negative flags
`timescale 1ns/1ps
`include "aie_map.svh"

module aie_adder #(
  parameter int WIDTH = 8
) (
  // operands
  input wire logic [WIDTH-1:0] a_i,
  input wire logic [WIDTH-1:0] b_i,
  // result
  output logic [WIDTH-1:0] sum_o,
  output logic [4:0] flags_o
);

  logic [WIDTH:0] full; // sum with carry out
  logic [4:0] nib; // low nibble sum for digit carry

  // plain add, flags derived from the sum
  always_comb begin
    full = {1'b0, a_i} + {1'b0, b_i};
    nib = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
    sum_o = full[WIDTH-1:0];
    flags_o = 5'h00;
    flags_o[`AIE_F_C] = full[WIDTH];
    flags_o[`AIE_F_DC] = nib[4];
    flags_o[`AIE_F_Z] = (full[WIDTH-1:0] == '0);
    // overflow: like signs in, other sign out
    flags_o[`AIE_F_OV] = (a_i[WIDTH-1] == b_i[WIDTH-1]) && (full[WIDTH-1] != a_i[WIDTH-1]);
    flags_o[`AIE_F_N] = full[WIDTH-1];
  end

endmodule

// File: logic/aie_core.sv
// add instruction execute core: decode, operand read, add, write back over four phases
// Notes on behaviour
// - upper byte 0000 1111: accumulator plus immediate
// - top bits 0010 01: accumulator plus file register
// - destination bit 0 accumulator, 1 file register
// - bank bit 0 access bank, 1 bank register
// - extended set, bank bit 0, f<=95: indexed
// - immediate add four phases, all five flags updated
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "aie_map.svh"

module aie_core #(
  parameter int AW = 12
) (
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // instruction stream
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  output logic instr_ready_o,
  output logic done_o,
  output logic illegal_o,
  // data memory port
  output logic [AW-1:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic [7:0] mem_rdata_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // observed state
  output logic [7:0] acc_o,
  output logic [4:0] flags_o
);

  aie_pkg::aie_state_e state_q; // current phase
  aie_pkg::aie_kind_e kind_q; // decoded kind
  logic [15:0] instr_q; // latched instruction word
  logic [7:0] acc_q; // accumulator
  logic [4:0] flags_q; // arithmetic flags
  logic [3:0] bank_q; // bank select register
  logic [AW-1:0] idx_q; // index base for literal offset mode
  logic ext_q; // extended instruction set enable
  logic [7:0] opnd_q; // literal operand
  logic [7:0] res_q; // sum held for write phase
  logic [4:0] rflags_q; // flags held for write phase
  logic ready_q, done_q, illegal_q;
  logic [AW-1:0] addr_q;
  logic rd_q, wr_q;
  logic [7:0] wdata_q;
  logic [15:0] rdata_q;
  logic [7:0] sum; // adder result
  logic [4:0] sflags; // adder flags
  logic [7:0] add_b; // second operand
  logic [7:0] fld; // file field of instruction
  logic [AW-1:0] faddr; // formed file address

  // classify an instruction word
  function automatic aie_pkg::aie_kind_e decode_kind(input logic [15:0] w);
    if (w[15:8] == `AIE_OPC_LIT) begin
      decode_kind = aie_pkg::KIND_LIT;
    end else if (w[15:10] == `AIE_OPC_FILE) begin
      decode_kind = aie_pkg::KIND_FILE;
    end else begin
      decode_kind = aie_pkg::KIND_NONE;
    end
  endfunction

  assign fld = instr_q[7:0];

  // file address: indexed, access bank or banked
  always_comb begin
    if (instr_q[`AIE_BIT_BANK]) begin
      faddr = AW'({bank_q, fld});
    end else if (ext_q && fld <= `AIE_IDX_LIMIT) begin
      faddr = idx_q + AW'(fld);
    end else if (fld < `AIE_ACCESS_SPLIT) begin
      faddr = AW'({`AIE_LOW_PAGE, fld});
    end else begin
      faddr = AW'({`AIE_SFR_PAGE, fld});
    end
  end

  // literal comes from the latch, file data arrives during process phase
  assign add_b = (kind_q == aie_pkg::KIND_LIT) ? opnd_q : mem_rdata_i;

  aie_adder #(
    .WIDTH(8)
  ) u_adder (
    .a_i(acc_q),
    .b_i(add_b),
    .sum_o(sum),
    .flags_o(sflags)
  );

  // phase sequencer, one phase per enabled clock
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= aie_pkg::ST_IDLE;
    end else if (ce_i) begin
      case (state_q)
        aie_pkg::ST_IDLE: begin
          if (instr_valid_i && ready_q) begin
            state_q <= aie_pkg::ST_DECODE;
          end
        end
        // unknown words end after decode without effect
        aie_pkg::ST_DECODE: begin
          if (decode_kind(instr_q) == aie_pkg::KIND_NONE) begin
            state_q <= aie_pkg::ST_IDLE;
          end else begin
            state_q <= aie_pkg::ST_READ;
          end
        end
        aie_pkg::ST_READ: state_q <= aie_pkg::ST_PROC;
        aie_pkg::ST_PROC: state_q <= aie_pkg::ST_WRITE;
        aie_pkg::ST_WRITE: state_q <= aie_pkg::ST_IDLE;
        default: state_q <= aie_pkg::ST_IDLE;
      endcase
    end
  end

  // instruction latch and handshake
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      instr_q <= 16'h0000;
      ready_q <= 1'b0;
      kind_q <= aie_pkg::KIND_NONE;
    end else if (ce_i) begin
      // ready only in idle so a word is never taken mid instruction
      ready_q <= (state_q == aie_pkg::ST_IDLE && !(instr_valid_i && ready_q)) ||
                 (state_q == aie_pkg::ST_WRITE) ||
                 (state_q == aie_pkg::ST_DECODE && decode_kind(instr_q) == aie_pkg::KIND_NONE);
      if (state_q == aie_pkg::ST_IDLE && instr_valid_i && ready_q) begin
        instr_q <= instr_i;
      end
      if (state_q == aie_pkg::ST_DECODE) begin
        kind_q <= decode_kind(instr_q);
      end
    end
  end

  // operand read phase and memory strobes
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_q <= '0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      wdata_q <= 8'h00;
      opnd_q <= 8'h00;
    end else if (ce_i) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      if (state_q == aie_pkg::ST_DECODE && decode_kind(instr_q) == aie_pkg::KIND_FILE) begin
        addr_q <= faddr;
        rd_q <= 1'b1;
      end
      if (state_q == aie_pkg::ST_DECODE) begin
        opnd_q <= instr_q[7:0];
      end
      // write back to the file in the fourth phase
      if (state_q == aie_pkg::ST_PROC && kind_q == aie_pkg::KIND_FILE && instr_q[`AIE_BIT_DEST]) begin
        wr_q <= 1'b1;
        wdata_q <= sum;
      end
    end
  end

  // process phase: hold sum and flags
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      res_q <= 8'h00;
      rflags_q <= `AIE_FLAGS_RST;
    end else if (ce_i && state_q == aie_pkg::ST_PROC) begin
      res_q <= sum;
      rflags_q <= sflags;
    end
  end

  // accumulator and flags; an instruction commit beats a register write
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_q <= `AIE_ACC_RST;
      flags_q <= `AIE_FLAGS_RST;
    end else if (ce_i) begin
      if (state_q == aie_pkg::ST_WRITE) begin
        flags_q <= rflags_q;
        if (kind_q == aie_pkg::KIND_LIT || !instr_q[`AIE_BIT_DEST]) begin
          acc_q <= res_q;
        end else if (reg_wr_i && reg_addr_i == `AIE_REG_ACC) begin
          acc_q <= reg_wdata_i[7:0];
        end
      end else begin
        if (reg_wr_i && reg_addr_i == `AIE_REG_ACC) begin
          acc_q <= reg_wdata_i[7:0];
        end
        if (reg_wr_i && reg_addr_i == `AIE_REG_FLAGS) begin
          flags_q <= reg_wdata_i[4:0];
        end
      end
    end
  end

  // completion pulses
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done_q <= 1'b0;
      illegal_q <= 1'b0;
    end else if (ce_i) begin
      done_q <= (state_q == aie_pkg::ST_WRITE);
      illegal_q <= (state_q == aie_pkg::ST_DECODE) && (decode_kind(instr_q) == aie_pkg::KIND_NONE);
    end
  end

  // configuration registers written by software
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ext_q <= `AIE_EXT_RST;
      bank_q <= `AIE_BANK_RST;
      idx_q <= `AIE_IDX_RST;
    end else if (ce_i && reg_wr_i) begin
      case (reg_addr_i)
        `AIE_REG_CTRL: ext_q <= reg_wdata_i[`AIE_CTRL_EXT];
        `AIE_REG_BANK: bank_q <= reg_wdata_i[3:0];
        `AIE_REG_IDX: idx_q <= reg_wdata_i[AW-1:0];
        default: ;
      endcase
    end
  end

  // read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= 16'h0000;
    end else if (ce_i) begin
      rdata_q <= 16'h0000;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `AIE_REG_CTRL: rdata_q <= {15'h0000, ext_q};
          `AIE_REG_ACC: rdata_q <= {8'h00, acc_q};
          `AIE_REG_FLAGS: rdata_q <= {11'h000, flags_q};
          `AIE_REG_BANK: rdata_q <= {12'h000, bank_q};
          `AIE_REG_IDX: rdata_q <= 16'(idx_q);
          `AIE_REG_STAT: rdata_q <= {15'h0000, state_q != aie_pkg::ST_IDLE};
          default: rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  assign instr_ready_o = ready_q;
  assign done_o = done_q;
  assign illegal_o = illegal_q;
  assign mem_addr_o = addr_q;
  assign mem_rd_o = rd_q;
  assign mem_wr_o = wr_q;
  assign mem_wdata_o = wdata_q;
  assign reg_rdata_o = rdata_q;
  assign acc_o = acc_q;
  assign flags_o = flags_q;

  // checks; a low enable aborts any attempt in flight
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i || !ce_i);

  lit_acc_write_a: assert property ((state_q == aie_pkg::ST_WRITE && kind_q == aie_pkg::KIND_LIT) |=>
    acc_q == $past(res_q)) else $error("immediate sum not in accumulator");
  file_decode_a: assert property ((state_q == aie_pkg::ST_DECODE && instr_q[15:10] == `AIE_OPC_FILE) |=>
    kind_q == aie_pkg::KIND_FILE && rd_q) else $error("file add not decoded");
  dest_select_a: assert property ((state_q == aie_pkg::ST_PROC && kind_q == aie_pkg::KIND_FILE) |=>
    wr_q == instr_q[`AIE_BIT_DEST] && (!wr_q || wdata_q == res_q)) else $error("destination select wrong");
  bank_addr_a: assert property ((state_q == aie_pkg::ST_READ && kind_q == aie_pkg::KIND_FILE
    && instr_q[`AIE_BIT_BANK]) |-> addr_q == AW'({bank_q, fld})) else $error("banked address wrong");
  indexed_addr_a: assert property ((state_q == aie_pkg::ST_READ && kind_q == aie_pkg::KIND_FILE
    && !instr_q[`AIE_BIT_BANK] && ext_q && fld <= `AIE_IDX_LIMIT) |-> addr_q == idx_q + AW'(fld))
    else $error("indexed address wrong");
  lit_flags_a: assert property ((state_q == aie_pkg::ST_WRITE && kind_q == aie_pkg::KIND_LIT) |=>
    flags_q[`AIE_F_Z] == (acc_q == 8'h00) && flags_q[`AIE_F_N] == acc_q[7]) else $error("flags not from sum");
  four_phase_a: assert property ((state_q == aie_pkg::ST_DECODE && decode_kind(instr_q) != aie_pkg::KIND_NONE)
    |=> state_q == aie_pkg::ST_READ ##1 state_q == aie_pkg::ST_PROC ##1 done_q == 1'b0 ##1 done_q)
    else $error("phase order broken");

  lit_done_c: cover property (state_q == aie_pkg::ST_WRITE && kind_q == aie_pkg::KIND_LIT);
  file_to_acc_c: cover property (wr_q == 1'b0 && state_q == aie_pkg::ST_WRITE && kind_q == aie_pkg::KIND_FILE);
  file_to_mem_c: cover property (wr_q);
  indexed_c: cover property (rd_q && ext_q && !instr_q[`AIE_BIT_BANK] && fld <= `AIE_IDX_LIMIT);

endmodule

// File: testbench/add_instruction_execute_tb.sv
// self-checking bench for the add execute core
`timescale 1ns/1ps
`include "aie_map.svh"

module add_instruction_execute_tb;
  logic clk_sys_i = 1'b0; // 50 MHz
  logic sys_rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic instr_valid_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic instr_ready_o, done_o, illegal_o, mem_rd_o, mem_wr_o;
  logic [11:0] mem_addr_o;
  logic [7:0] mem_wdata_o, acc_o;
  logic [7:0] mem_rdata_i = 8'h00;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] reg_rdata_o, rd_val;
  logic [4:0] flags_o;
  logic [7:0] mem [4096]; // data memory seen by the core
  logic [11:0] rd_addr_q, wr_addr_q;
  logic [7:0] wr_data_q;
  int wr_cnt = 0;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  aie_core i_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .instr_ready_o(instr_ready_o), .done_o(done_o), .illegal_o(illegal_o),
    .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .acc_o(acc_o), .flags_o(flags_o));

  // memory: data only the cycle after a read, inverted junk otherwise so stale data never passes
  always @(posedge clk_sys_i) begin
    if (mem_rd_o) begin
      rd_addr_q <= mem_addr_o;
      mem_rdata_i <= mem[mem_addr_o];
    end else begin
      mem_rdata_i <= ~mem_rdata_i;
    end
    if (mem_wr_o) begin
      wr_cnt <= wr_cnt + 1;
      wr_addr_q <= mem_addr_o;
      wr_data_q <= mem_wdata_o;
    end
  end

  // hang guard, far above the roughly 125 cycles the tests need
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count = bad_count + 1;
      give_verdict();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 rd_val = reg_rdata_o;
  endtask

  // offer one word, count edges from take to done or refusal
  task automatic run_instr(input logic [15:0] w, output int lat);
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b1;
    instr_i <= w;
    // hold the word until the edge at which ready is seen high
    do @(posedge clk_sys_i); while (instr_ready_o !== 1'b1);
    instr_valid_i <= 1'b0;
    for (lat = 1; lat < 9; lat++) begin
      @(posedge clk_sys_i);
      #1;
      if (done_o === 1'b1 || illegal_o === 1'b1) break;
    end
  endtask

  // reference flags {n, ov, z, dc, c}
  function automatic logic [4:0] exp_flags(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return {s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f, s[8]};
  endfunction

  task automatic lit_case(input logic [7:0] a, input logic [7:0] k);
    int lat;
    reg_write(`AIE_REG_ACC, {8'h00, a});
    run_instr({`AIE_OPC_LIT, k}, lat);
    check(16'(acc_o), 16'(8'(a + k)));
    check(16'(flags_o), 16'(exp_flags(a, k)));
    check(16'(lat), 16'h0004);
  endtask

  task automatic file_case(input bit d, input bit ab, input logic [7:0] f, input logic [7:0] a,
                           input logic [7:0] m, input logic [11:0] ea);
    int lat;
    int w0;
    reg_write(`AIE_REG_ACC, {8'h00, a});
    mem[ea] = m;
    w0 = wr_cnt;
    run_instr({`AIE_OPC_FILE, d, ab, f}, lat);
    check(16'(rd_addr_q), 16'(ea));
    check(16'(acc_o), 16'(d ? a : 8'(a + m)));
    check(16'(wr_cnt - w0), 16'(d));
    if (d) check({wr_addr_q, 4'h0}, {ea, 4'h0});
    if (d) check(16'(wr_data_q), 16'(8'(a + m)));
    check(16'(flags_o), 16'(exp_flags(a, m)));
    check(16'(lat), 16'h0004);
  endtask

  // accumulator reset value, ready after release, an unmapped offset
  task automatic reset_case();
    reg_read(`AIE_REG_ACC);
    check(rd_val, 16'h0000);
    check(16'(instr_ready_o), 16'h0001);
    reg_read(4'hf);
    check(rd_val, 16'h0000);
    @(posedge clk_sys_i);
    #1;
    check(reg_rdata_o, 16'h0000);
    $display("test reset done");
  endtask

  // a word of another instruction is refused and leaves the accumulator alone
  task automatic refused_case();
    int lat;
    run_instr(16'h2000, lat);
    check(16'(illegal_o), 16'h0001);
    check(16'(done_o), 16'h0000);
    check(16'(lat), 16'h0001);
    check(16'(acc_o), 16'h0010);
    $display("test refused done");
  endtask

  // low enable freezes state: a register write in that time is dropped
  task automatic freeze_case();
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    reg_write(`AIE_REG_ACC, 16'h0055);
    @(posedge clk_sys_i);
    ce_i <= 1'b1;
    #1;
    check(16'(acc_o), 16'h0010);
    check(16'(instr_ready_o), 16'h0001);
    $display("test freeze done");
  endtask

  // configuration and flag registers read back as written
  task automatic reg_case();
    reg_read(`AIE_REG_BANK);
    check(rd_val, 16'h0005);
    reg_read(`AIE_REG_IDX);
    check(rd_val, 16'h0fff);
    reg_read(`AIE_REG_CTRL);
    check(rd_val, 16'h0001);
    reg_read(`AIE_REG_STAT);
    check(rd_val, 16'h0000);
    reg_write(`AIE_REG_FLAGS, 16'h0015);
    reg_read(`AIE_REG_FLAGS);
    check(rd_val, 16'h0015);
    check(16'(flags_o), 16'h0015);
    $display("test registers done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'(i * 7);
    repeat (12) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    reset_case();
    // immediate adds: plain, carry plus overflow, zero, negative
    lit_case(8'h10, 8'h15);
    lit_case(8'h88, 8'h88);
    lit_case(8'hff, 8'h01);
    lit_case(8'h7f, 8'h01);
    $display("test immediate done");
    // file adds: access bank low and high page, banked, both destinations
    file_case(1'b0, 1'b0, 8'h42, 8'h17, 8'hc2, 12'h042);
    file_case(1'b1, 1'b0, 8'h90, 8'h01, 8'h7f, 12'hf90);
    reg_write(`AIE_REG_BANK, 16'h0005);
    file_case(1'b1, 1'b1, 8'h33, 8'h80, 8'h80, 12'h533);
    $display("test file done");
    // extended set: indexed at the limit, access just above it, index wrap
    reg_write(`AIE_REG_CTRL, 16'h0001);
    reg_write(`AIE_REG_IDX, 16'h0123);
    file_case(1'b1, 1'b0, 8'h5f, 8'h05, 8'h0b, 12'h182);
    file_case(1'b0, 1'b0, 8'h60, 8'h05, 8'h0b, 12'h060);
    reg_write(`AIE_REG_IDX, 16'h0fff);
    file_case(1'b0, 1'b0, 8'h01, 8'h0f, 8'h01, 12'h000);
    $display("test indexed done");
    refused_case();
    freeze_case();
    reg_case();
    give_verdict();
  end
endmodule
